// ===== logic/efh_pkg.sv
// Shared constants of the event flag handler.
package efh_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int EFH_NUM_SRC = 8;
    localparam int EFH_ADDR_W = 8;
    localparam int EFH_DATA_W = 32;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_FLAGS = 8'h00;
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_ENABLES = 8'h04;
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_TOP_CODE = 8'h08;
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_SUMMARY = 8'h0c;
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_IRQ_STAT = 8'h10;
    localparam logic [EFH_ADDR_W-1:0] EFH_OFS_IRQ_MASK = 8'h14;

    // ****************************************************************
    // Values after reset and field positions
    // ****************************************************************
    localparam logic [7:0] EFH_FLAGS_RST = 8'h00;
    localparam logic [7:0] EFH_ENABLES_RST = 8'h00;
    localparam logic [7:0] EFH_IRQ_STAT_RST = 8'h00;
    localparam logic [7:0] EFH_IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] EFH_CODE_NONE = 8'hff;
    localparam int EFH_SUM_HIGH_BIT = 1;
    localparam int EFH_SUM_LOW_BIT = 0;

endpackage

// ===== logic/efh_reg_if.sv
// Register access strobes between the bus slave and the register file.
`timescale 1ns/1ns
interface efh_reg_if;
    import efh_pkg::*;

    logic wr;
    logic rd;
    logic [EFH_ADDR_W-1:0] addr;
    logic [EFH_DATA_W-1:0] wdata;
    logic [EFH_DATA_W-1:0] rdata;
    logic [EFH_DATA_W-1:0] rdata_q;
    logic hit;

    modport bus_side (
        output wr, rd, addr, wdata, rdata_q,
        input rdata, hit
    );
    modport reg_side (
        input wr, rd, addr, wdata, rdata_q,
        output rdata, hit
    );
endinterface

// ===== logic/efh_edge_det.sv
// Two-stage synchroniser and rising edge detector for event sources.
`timescale 1ns/1ns
module efh_edge_det
    import efh_pkg::*;
#(
    parameter int W = EFH_NUM_SRC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [W-1:0] i_src,
    output logic [W-1:0] o_rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } efh_edge_state_t;

    efh_edge_state_t st_reg;
    efh_edge_state_t st_next;

    // The first stage feeds the second stage only.
    always_comb begin
        st_next = st_reg;
        st_next.s1 = i_src;
        st_next.s2 = st_reg.s1;
        st_next.prev = st_reg.s2;
        if (i_reset) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st_reg <= st_next;
    end

    assign o_rise = st_reg.s2 & ~st_reg.prev;

endmodule

// ===== logic/efh_apb_slave.sv
// APB slave front end turning transfers into register strobes.
`timescale 1ns/1ns
module efh_apb_slave
    import efh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [EFH_ADDR_W-1:0] i_paddr,
    input wire logic [EFH_DATA_W-1:0] i_pwdata,
    output logic [EFH_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    efh_reg_if.bus_side regs
);

    typedef struct packed {
        logic [EFH_DATA_W-1:0] prdata;
        logic pslverr;
    } efh_apb_state_t;

    efh_apb_state_t st_reg;
    efh_apb_state_t st_next;
    logic setup;
    logic access;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;

    // Read data is caught in the setup cycle so it leaves a flip-flop.
    always_comb begin
        st_next = st_reg;
        if (setup) begin
            st_next.prdata = regs.hit ? regs.rdata : '0;
            st_next.pslverr = ~regs.hit;
        end
        if (i_reset) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st_reg <= st_next;
    end

    // Unmapped addresses answer with an error and never write.
    assign regs.wr = access & i_pwrite & regs.hit;
    assign regs.rd = access & ~i_pwrite & regs.hit;
    assign regs.addr = i_paddr;
    assign regs.wdata = i_pwdata;
    assign regs.rdata_q = st_reg.prdata;
    assign o_prdata = st_reg.prdata;
    assign o_pslverr = st_reg.pslverr & access;
    assign o_pready = access;

endmodule

// ===== logic/efh_top.sv
// Event flag handler: latched event flags, priority code, core events.
//
// How it works
// - Eight event sources in two groups.
// - Bits seven to four high, three to zero low.
// - High group drives event A, low drives B.
// - Flags latch and stay pending afterwards.
// - Flag sets on enabled rising edge only.
// - Writing one clears flag, zero keeps.
// - Reset clears all flags.
// - Code is highest pending number, else ones.
// - Summary bit one high, zero low.
// - Code and summary follow latched flags.
// - Code register is read-only, writes ignored.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module efh_top
    import efh_pkg::*;
#(
    parameter int NUM_SRC = EFH_NUM_SRC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [EFH_ADDR_W-1:0] i_paddr,
    input wire logic [EFH_DATA_W-1:0] i_pwdata,
    output logic [EFH_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_SRC-1:0] i_event_src,
    output logic o_core_event_input_a,
    output logic o_core_event_input_b,
    output logic o_irq
);

    localparam int HALF = NUM_SRC / 2;

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // Registers are at most eight bits wide and split into two equal groups.
    generate
        if (NUM_SRC < 2 || NUM_SRC > 8 || (NUM_SRC % 2) != 0) begin : g_chk
            $error("NUM_SRC must be even and between 2 and 8.");
        end
    endgenerate

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] enables;
        logic [NUM_SRC-1:0] irq_stat;
        logic [NUM_SRC-1:0] irq_mask;
        logic evt_a;
        logic evt_b;
        logic irq;
    } efh_top_state_t;

    efh_top_state_t st_reg;
    efh_top_state_t st_next;
    logic [NUM_SRC-1:0] rise;
    logic [NUM_SRC-1:0] cap;
    logic [NUM_SRC-1:0] flag_clr;
    logic [NUM_SRC-1:0] stat_clr;
    logic [7:0] top_code;
    logic [7:0] summary;

    efh_reg_if regs ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Highest set bit wins; an empty vector gives the all-ones code.
    function automatic logic [7:0] efh_prio(input logic [NUM_SRC-1:0] f);
        logic [7:0] code;
        code = EFH_CODE_NONE;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (f[i]) begin
                code = 8'(i);
            end
        end
        return code;
    endfunction

    function automatic logic reg_hit(input logic [EFH_ADDR_W-1:0] a,
                                     input logic [EFH_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // ****************************************************************
    // Submodules
    // ****************************************************************
    efh_apb_slave u_apb (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .regs(regs.bus_side)
    );

    // Sources come from other logic and may be asynchronous to us.
    efh_edge_det #(
        .W(NUM_SRC)
    ) u_edge (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_src(i_event_src),
        .o_rise(rise)
    );

    // ****************************************************************
    // Derived views
    // ****************************************************************
    // Views from latched flags.
    assign top_code = efh_prio(st_reg.flags);

    always_comb begin
        summary = 8'h00;
        summary[EFH_SUM_HIGH_BIT] = |st_reg.flags[NUM_SRC-1:HALF];
        summary[EFH_SUM_LOW_BIT] = |st_reg.flags[HALF-1:0];
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    // Code is read-only.
    always_comb begin
        regs.rdata = '0;
        regs.hit = 1'b1;
        unique case (regs.addr)
            EFH_OFS_FLAGS: regs.rdata = 32'(st_reg.flags);
            EFH_OFS_ENABLES: regs.rdata = 32'(st_reg.enables);
            EFH_OFS_TOP_CODE: regs.rdata = 32'(top_code);
            EFH_OFS_SUMMARY: regs.rdata = 32'(summary);
            EFH_OFS_IRQ_STAT: regs.rdata = 32'(st_reg.irq_stat);
            EFH_OFS_IRQ_MASK: regs.rdata = 32'(st_reg.irq_mask);
            default: regs.hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Capture enabled edges.
    assign cap = rise & st_reg.enables;

    assign flag_clr = (regs.wr && reg_hit(regs.addr, EFH_OFS_FLAGS)) ?
        regs.wdata[NUM_SRC-1:0] : '0;

    // Only bits the reader actually saw are cleared, so an event
    // arriving between setup and access is kept for the next read.
    assign stat_clr = (regs.rd && reg_hit(regs.addr, EFH_OFS_IRQ_STAT)) ?
        regs.rdata_q[NUM_SRC-1:0] : '0;

    always_comb begin
        st_next = st_reg;
        st_next.flags = (st_reg.flags & ~flag_clr) | cap;
        if (regs.wr && reg_hit(regs.addr, EFH_OFS_ENABLES)) begin
            st_next.enables = regs.wdata[NUM_SRC-1:0];
        end
        st_next.irq_stat = (st_reg.irq_stat & ~stat_clr) | cap;
        if (regs.wr && reg_hit(regs.addr, EFH_OFS_IRQ_MASK)) begin
            st_next.irq_mask = regs.wdata[NUM_SRC-1:0];
        end
        st_next.evt_a = |st_next.flags[NUM_SRC-1:HALF];
        st_next.evt_b = |st_next.flags[HALF-1:0];
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
        if (i_reset) begin
            st_next.flags = NUM_SRC'(EFH_FLAGS_RST);
            st_next.enables = NUM_SRC'(EFH_ENABLES_RST);
            st_next.irq_stat = NUM_SRC'(EFH_IRQ_STAT_RST);
            st_next.irq_mask = NUM_SRC'(EFH_IRQ_MASK_RST);
            st_next.evt_a = 1'b0;
            st_next.evt_b = 1'b0;
            st_next.irq = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st_reg <= st_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Two core event lines.
    assign o_core_event_input_a = st_reg.evt_a;
    assign o_core_event_input_b = st_reg.evt_b;
    assign o_irq = st_reg.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic wr_flags;
    assign wr_flags = regs.wr && reg_hit(regs.addr, EFH_OFS_FLAGS);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    property p_set_on_edge;
        (cap != '0) |=> ((st_reg.flags & $past(cap)) == $past(cap));
    endproperty
    a_set_on_edge: assert property (p_set_on_edge)
        else $error("Enabled edge did not set its flag.");

    property p_no_stray_set;
        ((st_reg.flags & ~$past(st_reg.flags) & ~$past(cap)) == '0);
    endproperty
    a_no_stray_set: assert property (p_no_stray_set)
        else $error("Flag set without an enabled edge.");

    property p_w1c;
        wr_flags |=>
            ((st_reg.flags & $past(flag_clr) & ~$past(cap)) == '0);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Write of one did not clear the flag.");

    property p_sticky;
        (st_reg.flags != '0) && !wr_flags |=>
            ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Pending flag dropped without a clear.");

    property p_set_wins;
        ((cap & flag_clr) != '0) |=>
            ((st_reg.flags & $past(cap & flag_clr)) != '0);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Edge lost against a clear.");

    property p_reset_state;
        disable iff (1'b0)
        i_reset |=> (st_reg.flags == '0) && (st_reg.enables == '0)
            && (top_code == EFH_CODE_NONE);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Reset left flags, enables or code set.");

    property p_code_none;
        (st_reg.flags == '0) |-> (top_code == 8'hff);
    endproperty
    a_code_none: assert property (p_code_none)
        else $error("Empty flags did not give all ones.");

    property p_code_top;
        st_reg.flags[NUM_SRC-1] |-> (top_code == 8'(NUM_SRC - 1));
    endproperty
    a_code_top: assert property (p_code_top)
        else $error("Highest flag did not win the code.");

    property p_summary_high;
        (st_reg.flags[NUM_SRC-1:HALF] != '0) |-> summary[1] && !summary[7];
    endproperty
    a_summary_high: assert property (p_summary_high)
        else $error("High summary bit wrong.");

    property p_core_a;
        o_core_event_input_a ==
            (st_reg.flags[NUM_SRC-1:HALF] != '0);
    endproperty
    a_core_a: assert property (p_core_a)
        else $error("Event line A not following high flags.");

    property p_core_b;
        o_core_event_input_b == (st_reg.flags[HALF-1:0] != '0);
    endproperty
    a_core_b: assert property (p_core_b)
        else $error("Event line B not following low flags.");

    property p_irq;
        ((st_reg.irq_stat & st_reg.irq_mask) != '0) |-> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt not raised for unmasked status.");

    c_flag_set: cover property (cap != '0 ##1 st_reg.flags != '0);
    c_clear: cover property (wr_flags && (st_reg.flags & flag_clr) != '0);
    c_both_lines: cover property (o_core_event_input_a
        && o_core_event_input_b);
    c_set_wins: cover property ((cap & flag_clr) != '0);
    c_irq: cover property ($rose(o_irq));

endmodule

// ===== tb/efh_src_model.sv
// Behavioural event sources that sit in front of the handler.
`timescale 1ns/1ns
module efh_src_model
    import efh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [EFH_NUM_SRC-1:0] i_fire,
    output logic [EFH_NUM_SRC-1:0] o_src
);
    logic [EFH_NUM_SRC-1:0] fire_reg;

    // Each request becomes a two-cycle pulse, then the line idles low.
    // A one-cycle pulse would be fine here, but two mimics a slow source.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            fire_reg <= '0;
            o_src <= '0;
        end else begin
            fire_reg <= i_fire;
            o_src <= i_fire | fire_reg;
        end
    end
endmodule

// ===== tb/efh_top_bench.sv
// Self-checking bench for the event flag handler.
`timescale 1ns/1ns
module efh_top_bench;
    import efh_pkg::*;
    logic i_clk_sys, i_reset, i_psel, i_penable, i_pwrite;
    logic [EFH_ADDR_W-1:0] i_paddr;
    logic [EFH_DATA_W-1:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr, o_irq;
    logic o_core_event_input_a, o_core_event_input_b;
    logic [EFH_NUM_SRC-1:0] fire, src;
    logic [32:0] exp_q[$];
    logic [7:0] addr_q[$];
    logic [32:0] exp_w;
    logic [7:0] exp_a, en_m, flg_m, stat_m;
    logic irq_m;
    int err_total, num_checks, seed, i;

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    efh_top efh_top_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_event_src(src),
        .o_core_event_input_a(o_core_event_input_a),
        .o_core_event_input_b(o_core_event_input_b), .o_irq(o_irq)
    );

    efh_src_model efh_src_model_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_fire(fire),
        .o_src(src)
    );

    // ****************************************************************
    // Comparison and bus tasks
    // ****************************************************************
    task automatic check_val(input string what, input logic [32:0] exp,
                             input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_pins();
        check_val("pins", {30'h0, |flg_m[7:4], |flg_m[3:0], irq_m},
                  {30'h0, o_core_event_input_a, o_core_event_input_b, o_irq});
    endtask

    // The request stays put until pready is seen high at an edge.
    task automatic apb_go(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // One idle cycle, so a following call never drives twice at once.
        @(posedge i_clk_sys);
    endtask

    task automatic apb_read(input logic [7:0] a, input logic [31:0] d,
                            input logic e);
        exp_q.push_back({e, d});
        addr_q.push_back(a);
        apb_go(1'b0, a, 32'h0);
    endtask

    // Reads are judged here, at the edge that takes the data.
    always @(posedge i_clk_sys) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("wrong value read expected none seen %h", o_prdata);
            end else begin
                exp_w = exp_q.pop_front();
                exp_a = addr_q.pop_front();
                check_val($sformatf("read %h", exp_a), exp_w,
                          {o_pslverr, o_prdata});
            end
        end
    end

    task automatic pulse(input logic [7:0] m);
        fire <= m;
        flg_m = flg_m | (m & en_m);
        stat_m = stat_m | (m & en_m);
        @(posedge i_clk_sys);
        fire <= '0;
        repeat (5) @(posedge i_clk_sys);
    endtask

    task automatic check_state();
        logic [7:0] c;
        c = 8'hff;
        for (int k = 0; k < 8; k++) if (flg_m[k]) c = 8'(k);
        apb_read(EFH_OFS_FLAGS, {24'h0, flg_m}, 1'b0);
        apb_read(EFH_OFS_TOP_CODE, {24'h0, c}, 1'b0);
        apb_read(EFH_OFS_SUMMARY,
                 {30'h0, |flg_m[7:4], |flg_m[3:0]}, 1'b0);
        check_pins();
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        err_total++;
        complete_run();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 64222;
        err_total = 0;
        num_checks = 0;
        i_reset = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = '0;
        i_pwdata = '0;
        fire = '0;
        en_m = 8'h00;
        flg_m = 8'h00;
        stat_m = 8'h00;
        irq_m = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        check_state();
        apb_read(EFH_OFS_ENABLES, 32'h0, 1'b0);
        apb_read(EFH_OFS_IRQ_MASK, 32'h0, 1'b0);
        pulse(8'hff);
        check_state();
        apb_go(1'b1, EFH_OFS_ENABLES, 32'h5a);
        en_m = 8'h5a;
        apb_read(EFH_OFS_ENABLES, 32'h5a, 1'b0);
        pulse(8'hff);
        check_state();
        apb_go(1'b1, EFH_OFS_FLAGS, 32'h0);
        check_state();
        apb_go(1'b1, EFH_OFS_FLAGS, 32'h40);
        flg_m = 8'h1a;
        check_state();
        apb_go(1'b1, EFH_OFS_FLAGS, 32'hff);
        apb_go(1'b1, EFH_OFS_ENABLES, 32'hff);
        flg_m = 8'h00;
        en_m = 8'hff;
        for (i = 0; i < 8; i++) begin
            pulse(8'(8'h01 << i));
            check_state();
            apb_go(1'b1, EFH_OFS_FLAGS, {24'h0, flg_m});
            flg_m = 8'h00;
        end
        pulse(8'h09);
        apb_go(1'b1, EFH_OFS_TOP_CODE, 32'h0);
        check_state();
        // Clear lands on the very edge that captures a new rise.
        fire <= 8'h01;
        @(posedge i_clk_sys);
        fire <= '0;
        @(posedge i_clk_sys);
        apb_go(1'b1, EFH_OFS_FLAGS, 32'h01);
        check_state();
        apb_read(8'h18, 32'h0, 1'b1);
        apb_read(8'h01, 32'h0, 1'b1);
        apb_read(EFH_OFS_IRQ_STAT, {24'h0, stat_m}, 1'b0);
        stat_m = 8'h00;
        apb_read(EFH_OFS_IRQ_STAT, 32'h0, 1'b0);
        apb_go(1'b1, EFH_OFS_IRQ_MASK, 32'h10);
        apb_read(EFH_OFS_IRQ_MASK, 32'h10, 1'b0);
        pulse(8'h20);
        check_state();
        pulse(8'h10);
        irq_m = 1'b1;
        check_state();
        apb_read(EFH_OFS_IRQ_STAT, {24'h0, stat_m}, 1'b0);
        stat_m = 8'h00;
        irq_m = 1'b0;
        check_pins();
        apb_go(1'b1, EFH_OFS_IRQ_MASK, 32'h0);
        apb_go(1'b1, EFH_OFS_FLAGS, 32'hff);
        flg_m = 8'h00;
        repeat (12) begin
            en_m = 8'($random(seed));
            apb_go(1'b1, EFH_OFS_ENABLES, {24'h0, en_m});
            pulse(8'($random(seed)));
            check_state();
        end
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        flg_m = 8'h00;
        en_m = 8'h00;
        @(posedge i_clk_sys);
        check_state();
        apb_read(EFH_OFS_ENABLES, 32'h0, 1'b0);
        repeat (3) @(posedge i_clk_sys);
        complete_run();
    end
endmodule
